//--- acs_pkg.sv
`default_nettype none
package acs_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] ACS_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACS_CHAN_OFS = 8'h04;
  localparam logic [7:0] ACS_RESLO_OFS = 8'h08;
  localparam logic [7:0] ACS_RESHI_OFS = 8'h0C;
  localparam logic [7:0] ACS_STAT_OFS = 8'h10;
  localparam logic [7:0] ACS_MASK_OFS = 8'h14;
  // Control register field positions and widths, channel and result widths
  localparam int ACS_EN_BIT = 0;
  localparam int ACS_START_BIT = 1;
  localparam int ACS_FREE_BIT = 2;
  localparam int ACS_PSC_LSB = 3;
  localparam int ACS_PSC_W = 3;
  localparam int ACS_CHAN_W = 3;
  localparam int ACS_RES_W = 10;
  // Reset values, SAR midscale trial code and MSB bit index
  localparam logic [ACS_PSC_W-1:0] ACS_PSC_RST = 3'h0;
  localparam logic [ACS_CHAN_W-1:0] ACS_CHAN_RST = 3'h0;
  localparam logic [ACS_RES_W-1:0] ACS_RES_RST = 10'h000;
  localparam logic [ACS_RES_W-1:0] ACS_SAR_MID = 10'h200;
  localparam logic [3:0] ACS_MSB_IDX = 4'h9;
  // Conversion timing in converter clock cycles
  localparam logic [4:0] ACS_NORM_CYCLES = 5'd13;
  localparam logic [4:0] ACS_EXT_CYCLES = 5'd25;
  localparam logic [4:0] ACS_NORM_SAMPLE = 5'd1;
  localparam logic [4:0] ACS_EXT_SAMPLE = 5'd13;
  localparam logic [4:0] ACS_RES_BITS = 5'd10;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_WAIT = 2'b01,
    ACS_CONV = 2'b10
  } acs_fsm_type;

  typedef struct packed {
    acs_fsm_type fsm;
    logic en;
    logic start;
    logic freeRun;
    logic [ACS_PSC_W-1:0] presc;
    logic [ACS_CHAN_W-1:0] chanSel;
    logic [ACS_CHAN_W-1:0] anaChan;
    logic [4:0] cyc;
    logic ext;
    logic [3:0] bitIdx;
    logic [ACS_RES_W-1:0] sar;
    logic [ACS_RES_W-1:0] result;
    logic lock;
    logic done;
    logic mask;
    logic sampleHold;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] compSync;
  } acs_top_type;

  typedef struct packed {
    logic [7:0] cnt;
  } acs_psc_type;
endpackage : acs_pkg
`default_nettype wire

//--- acs_psc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acs_psc_if;
  import acs_pkg::*;
  logic enable;
  logic [ACS_PSC_W-1:0] sel;
  logic rise;
  logic fall;
  modport ctl (output enable, output sel, input rise, input fall);
  modport psc (input enable, input sel, output rise, output fall);
endinterface : acs_psc_if
`default_nettype wire

//--- acs_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
  input wire logic clk_sys, // System clock
  input wire logic nrst, // Async reset, active low
  acs_psc_if.psc link // Enable, select and ticks
);
  import acs_pkg::*;

  acs_psc_type r;
  acs_psc_type n;
  logic [7:0] lim;

  // Division factor is 2 shifted by select; 256 wraps to a limit of 255
  assign lim = 8'((9'd2 << link.sel) - 9'd1);
  assign link.rise = link.enable && (r.cnt == lim);
  assign link.fall = link.enable && (r.cnt == (lim >> 1));

  // Counter held at zero while the converter is off
  always_comb
  begin
    n = r;
    if (!link.enable) n.cnt = 8'h00;
    else if (r.cnt == lim) n.cnt = 8'h00;
    else n.cnt = r.cnt + 8'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst) r <= '0;
    else r <= n;
  end

  a_psc_held_off: assert property (
    @(posedge clk_sys) disable iff (!nrst) !link.enable |=> (r.cnt == 8'h00) && !link.rise)
    else $error("prescaler ran while disabled");

  a_psc_rise_gap: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    link.rise && link.sel == 3'h1 && $stable(link.sel) |=> !link.rise [*3] ##1 link.rise)
    else $error("divide by four tick spacing wrong");
endmodule : acs_prescaler
`default_nettype wire

//--- acs_conv_seq.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Ten-bit successive approximation, one bit per cycle
// - Eight-way channel select drives analog mux
// - Mode bit picks single or free running
// - Channel applies only while converter enabled
// - Start bit reads high until conversion ends
// - Channel change waits for current conversion end
// - Low byte read locks result until high read
// - Done flag sets even when result discarded
// - Prescaler runs only while enabled, else reset
// - Conversion begins on next converter clock rise
// - Normal 13 cycles, first after enable 25
// - Sample-hold at 1.5 or 13.5 cycles
// - Completion stores result, flags, clears start
// - Free running restarts at once, start stays
// - Ground gives zero, reference minus step full
// - Late free-run channel change hits next conversion
module acs_conv_seq #(
  parameter int ADDR_W = 8 // APB address width
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic irq, // Level interrupt
  input wire logic compIn, // Comparator: input above trial code
  output logic [acs_pkg::ACS_CHAN_W-1:0] anaChannel, // Analog mux select
  output logic sampleHold, // One-cycle sample-and-hold strobe
  output logic [acs_pkg::ACS_RES_W-1:0] sarCode, // Trial code to the DAC
  output logic convBusy // Conversion running
);
  import acs_pkg::*;

  acs_top_type r;
  acs_top_type n;
  logic setupPh;
  logic accessPh;
  logic mapped;
  logic blockUpd;
  logic doneEv;
  logic [4:0] sIdx;
  logic [4:0] total;
  logic [31:0] rdMux;

  acs_psc_if pscIf ();

  acs_prescaler u_psc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .link(pscIf.ctl)
  );

  // Prescaler follows the enable bit and select field
  assign pscIf.enable = r.en;
  assign pscIf.sel = r.presc;

  // Bus phases; pready comes from a flop, so each access takes one wait-free access cycle
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable && r.pready;
  assign mapped = (8'(paddr) == ACS_CTRL_OFS) || (8'(paddr) == ACS_CHAN_OFS)
    || (8'(paddr) == ACS_RESLO_OFS) || (8'(paddr) == ACS_RESHI_OFS)
    || (8'(paddr) == ACS_STAT_OFS) || (8'(paddr) == ACS_MASK_OFS);

  // A low-byte read already in setup blocks updates, so the snapshot stays paired
  assign blockUpd = r.lock
    || (psel && !pwrite && 8'(paddr) == ACS_RESLO_OFS);

  // Timing of the running conversion depends on whether it is extended
  assign sIdx = r.ext ? ACS_EXT_SAMPLE : ACS_NORM_SAMPLE;
  assign total = r.ext ? ACS_EXT_CYCLES : ACS_NORM_CYCLES;

  // Read data mux, captured during the setup cycle
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (8'(paddr))
      ACS_CTRL_OFS:
      begin
        rdMux[ACS_EN_BIT] = r.en;
        rdMux[ACS_START_BIT] = r.start;
        rdMux[ACS_FREE_BIT] = r.freeRun;
        rdMux[ACS_PSC_LSB +: ACS_PSC_W] = r.presc;
      end
      ACS_CHAN_OFS: rdMux[ACS_CHAN_W-1:0] = r.chanSel;
      ACS_RESLO_OFS: rdMux[7:0] = r.result[7:0];
      ACS_RESHI_OFS: rdMux[1:0] = r.result[9:8];
      ACS_STAT_OFS: rdMux[0] = r.done;
      ACS_MASK_OFS: rdMux[0] = r.mask;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Next-state logic for bus, sequencer and status
  always_comb
  begin
    n = r;
    doneEv = 1'b0;
    n.compSync = {r.compSync[0], compIn};
    n.sampleHold = 1'b0;
    n.pready = setupPh;
    n.pslverr = setupPh && !mapped;
    if (setupPh) n.prdata = rdMux;

    // Register writes take effect at the access edge
    if (accessPh && pwrite)
    begin
      case (8'(paddr))
        ACS_CTRL_OFS:
        begin
          n.en = pwdata[ACS_EN_BIT];
          n.freeRun = pwdata[ACS_FREE_BIT];
          n.presc = pwdata[ACS_PSC_LSB +: ACS_PSC_W];
          // Writing zero never aborts a running conversion
          if (pwdata[ACS_START_BIT] && pwdata[ACS_EN_BIT]) n.start = 1'b1;
        end
        ACS_CHAN_OFS: n.chanSel = pwdata[ACS_CHAN_W-1:0];
        ACS_MASK_OFS: n.mask = pwdata[0];
        default: n.mask = r.mask;
      endcase
    end

    // Result byte order: low read locks, high read unlocks
    if (accessPh && !pwrite && 8'(paddr) == ACS_RESLO_OFS) n.lock = 1'b1;
    if (accessPh && !pwrite && 8'(paddr) == ACS_RESHI_OFS) n.lock = 1'b0;

    // Conversion sequencer
    case (r.fsm)
      ACS_IDLE:
      begin
        if (r.start && r.en) n.fsm = ACS_WAIT;
      end
      ACS_WAIT:
      begin
        if (pscIf.rise)
        begin
          n.fsm = ACS_CONV;
          n.cyc = 5'd0;
          n.anaChan = r.chanSel;
        end
      end
      ACS_CONV:
      begin
        if (pscIf.fall && r.cyc == sIdx)
        begin
          n.sampleHold = 1'b1;
          n.sar = ACS_SAR_MID;
          n.bitIdx = ACS_MSB_IDX;
        end
        if (pscIf.rise)
        begin
          n.cyc = r.cyc + 5'd1;
          // One bit decided per converter cycle after sampling
          if (r.cyc > sIdx && r.cyc <= sIdx + ACS_RES_BITS)
          begin
            if (!r.compSync[1]) n.sar[r.bitIdx] = 1'b0;
            if (r.bitIdx != 4'h0)
            begin
              n.sar[r.bitIdx - 4'h1] = 1'b1;
              n.bitIdx = r.bitIdx - 4'h1;
            end
          end
          if (r.cyc + 5'd1 == total)
          begin
            doneEv = 1'b1;
            if (!blockUpd) n.result = r.sar;
            n.ext = 1'b0;
            if (r.freeRun)
            begin
              n.cyc = 5'd0;
              n.anaChan = r.chanSel;
            end
            else
            begin
              n.fsm = ACS_IDLE;
              n.start = 1'b0;
            end
          end
        end
      end
      default: n.fsm = ACS_IDLE;
    endcase

    // Disabling abandons any conversion; the next one is extended
    if (!n.en)
    begin
      n.fsm = ACS_IDLE;
      n.start = 1'b0;
      n.ext = 1'b1;
    end

    // Sticky flag: write one clears, a same-cycle completion wins
    n.done = r.done;
    if (accessPh && pwrite && 8'(paddr) == ACS_STAT_OFS && pwdata[0]) n.done = 1'b0;
    if (doneEv) n.done = 1'b1;
    n.irq = n.done && n.mask;
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.fsm <= ACS_IDLE;
      r.presc <= ACS_PSC_RST;
      r.chanSel <= ACS_CHAN_RST;
      r.anaChan <= ACS_CHAN_RST;
      r.result <= ACS_RES_RST;
      r.ext <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign anaChannel = r.anaChan;
  assign sampleHold = r.sampleHold;
  assign sarCode = r.sar;
  // Only the converting state has bit 1 set, so this is a plain flop bit
  assign convBusy = r.fsm[1];

  a_single_clears_start: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    doneEv && !r.freeRun && r.en |=> !r.start && r.fsm == ACS_IDLE && r.done)
    else $error("single conversion did not clear start");

  a_free_restart: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    doneEv && r.freeRun && n.en |=> r.start && r.fsm == ACS_CONV && r.cyc == 5'd0)
    else $error("free running did not restart");

  a_lock_holds: assert property (
    @(posedge clk_sys) disable iff (!nrst) r.lock |=> $stable(r.result))
    else $error("result changed while locked");

  a_flag_on_lost: assert property (
    @(posedge clk_sys) disable iff (!nrst) doneEv && r.lock |=> r.done && $stable(r.result))
    else $error("lost result did not set flag");

  a_sample_point: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    r.sampleHold |-> r.cyc == (r.ext ? ACS_EXT_SAMPLE : ACS_NORM_SAMPLE) && r.sar == ACS_SAR_MID)
    else $error("sample-hold at wrong cycle");

  a_conv_length: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    doneEv |-> (r.ext && r.cyc == 5'd24) || (!r.ext && r.cyc == 5'd12))
    else $error("conversion length wrong");

  a_chan_held: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    r.fsm == ACS_CONV && !doneEv && n.en |=> $stable(anaChannel))
    else $error("channel moved mid conversion");

  a_start_on_rise: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    r.fsm == ACS_WAIT && pscIf.rise && r.en |=> r.fsm == ACS_CONV && r.cyc == 5'd0)
    else $error("conversion did not start on tick");

  a_irq_gate: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    doneEv ##1 r.mask |=> irq)
    else $error("enabled flag gave no interrupt");

  a_chan_needs_en: assert property (
    @(posedge clk_sys) disable iff (!nrst) !r.en |=> $stable(anaChannel))
    else $error("channel applied while disabled");

  // While enabled, the waiting state leaves only on a converter clock rise
  a_wait_for_tick: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    r.fsm == ACS_WAIT && !pscIf.rise && n.en |=> r.fsm == ACS_WAIT)
    else $error("conversion began without tick");

  // Start bit stays readable high while converting
  a_start_high_conv: assert property (
    @(posedge clk_sys) disable iff (!nrst) r.fsm == ACS_CONV |-> r.start)
    else $error("start low during conversion");

  // Disabled converter is idle and arms an extended conversion
  a_disable_resets: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !r.en |-> r.ext && r.fsm == ACS_IDLE && !r.start)
    else $error("disabled converter not reset");

  // Completion with mask kept set raises the line at once
  a_irq_on_done: assert property (
    @(posedge clk_sys) disable iff (!nrst) doneEv && n.mask |=> irq)
    else $error("no interrupt on completion");

  // Sample strobe is a single clock wide
  a_sh_pulse: assert property (
    @(posedge clk_sys) disable iff (!nrst) sampleHold |=> !sampleHold)
    else $error("sample strobe too long");

  // All ten decisions are made before completion
  a_all_bits_decided: assert property (
    @(posedge clk_sys) disable iff (!nrst) doneEv |-> r.bitIdx == 4'h0)
    else $error("completion before last bit");

  // Mux select takes the written channel at conversion start
  a_chan_latch: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    r.fsm == ACS_WAIT && pscIf.rise && r.en |=> anaChannel == $past(r.chanSel))
    else $error("channel not latched at start");

  // Low byte read sets the lock
  a_lock_by_low: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    accessPh && !pwrite && 8'(paddr) == ACS_RESLO_OFS |=> r.lock)
    else $error("low read did not lock");

  // High byte read releases the lock
  a_unlock_by_high: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    accessPh && !pwrite && 8'(paddr) == ACS_RESHI_OFS |=> !r.lock)
    else $error("high read did not unlock");
endmodule : acs_conv_seq
`default_nettype wire

//--- acs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
  input wire logic clk_sys, // System clock
  input wire logic [2:0] anaChannel, // Selected input
  input wire logic [9:0] sarCode, // Trial code
  input wire logic slow, // Late comparator answer
  input wire logic [79:0] vin, // Eight input levels as codes
  output logic compIn // Comparator out
);
  logic cmp;
  logic [1:0] dly;
  // Mux picks one of eight inputs; ground level is code zero
  assign cmp = vin[anaChannel*10 +: 10] >= sarCode;
  // Slow answer lags two clocks, still inside the settle time
  always @(posedge clk_sys) dly <= {dly[0], cmp};
  assign compIn = slow ? dly[1] : cmp;
endmodule : acs_analog_model
`default_nettype wire

//--- acs_conv_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acs_conv_seq_tb_top;
  import acs_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, compIn, sampleHold, convBusy, slow;
  logic [2:0] anaChannel;
  logic [9:0] sarCode;
  logic [79:0] vin;
  int errCount = 0;
  int checksDone = 0;
  int run = 0;
  int lastLen = 0;
  int shAt = 0;
  int cycles = 0;

  acs_conv_seq i_dut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .compIn(compIn), .anaChannel(anaChannel),
    .sampleHold(sampleHold), .sarCode(sarCode), .convBusy(convBusy));
  acs_analog_model i_ana (.clk_sys(clk_sys), .anaChannel(anaChannel), .sarCode(sarCode),
    .slow(slow), .vin(vin), .compIn(compIn));

  always #5 clk_sys = ~clk_sys;

  // Busy stretch length and sample point; bounded run time
  always @(posedge clk_sys)
  begin
    if (convBusy === 1'b1)
      run <= run + 1;
    else
    begin
      if (run != 0)
        lastLen <= run;
      run <= 0;
    end
    if (sampleHold === 1'b1)
      shAt <= run;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errCount++;
      print_verdict();
    end
  end

  function automatic logic [9:0] lvl(int c);
    return (c == 7) ? 10'h3FF : 10'(c) * 10'h093;
  endfunction : lvl

  task automatic print_verdict();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checksDone++;
    if (s !== x)
    begin
      errCount++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      errCount++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
  endtask : rd

  // Poll a register bit until it reaches the wanted level
  task automatic waitBit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    int n;
    n = 0;
    do
    begin
      rd(a, r);
      n++;
    end
    while (r[b] !== v && n < 300);
    chk(32'(r[b]), 32'(v));
  endtask : waitBit

  // Low byte first, then high byte
  task automatic getRes(output logic [9:0] v);
    logic [31:0] lo, hi;
    rd(ACS_RESLO_OFS, lo);
    rd(ACS_RESHI_OFS, hi);
    v = {hi[1:0], lo[7:0]};
  endtask : getRes

  task automatic conv(input logic [31:0] c);
    logic [31:0] r;
    wr(ACS_CTRL_OFS, c | 32'h3);
    rd(ACS_CTRL_OFS, r);
    chk(32'(r[1]), 32'h1);
    waitBit(ACS_CTRL_OFS, 1, 1'b0);
  endtask : conv

  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(ACS_CTRL_OFS, r);
    chk(r, 32'h0);
    rd(ACS_STAT_OFS, r);
    chk(r, 32'h0);
    apb(8'h18, 1'b0, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    wr(ACS_CHAN_OFS, 32'h6);
    chk(32'(anaChannel), 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_chans();
    logic [9:0] v;
    int sh;
    // Divide by eight: far above full-resolution clock, kept short on purpose
    wr(ACS_CTRL_OFS, 32'h11);
    for (int c = 0; c < 8; c++)
    begin
      wr(ACS_CHAN_OFS, 32'(c));
      conv(32'h10);
      chk(32'(anaChannel), 32'(c));
      chk(32'(sarCode), 32'(lvl(c)));
      chk(32'(lastLen), (c == 0) ? 32'd200 : 32'd104);
      if (c == 0)
        sh = shAt;
      if (c == 1)
        chk(32'(sh - shAt), 32'd96);
      getRes(v);
      chk(32'(v), 32'(lvl(c)));
    end
    $display("t_chans done");
  endtask : t_chans

  task automatic t_psc();
    wr(ACS_CTRL_OFS, 32'h19);
    conv(32'h18);
    chk(32'(lastLen), 32'd208);
    wr(ACS_CTRL_OFS, 32'h0);
    wr(ACS_CTRL_OFS, 32'h19);
    conv(32'h18);
    chk(32'(lastLen), 32'd400);
    $display("t_psc done");
  endtask : t_psc

  task automatic t_lock();
    logic [31:0] r;
    logic [9:0] v;
    wr(ACS_STAT_OFS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(ACS_MASK_OFS, 32'h1);
    rd(ACS_RESLO_OFS, r);
    vin[29:20] <= 10'h13A;
    wr(ACS_CHAN_OFS, 32'h2);
    conv(32'h10);
    chk(32'(irq), 32'h1);
    rd(ACS_RESHI_OFS, r);
    chk({r[1:0], 8'h00}, {22'h0, lvl(7) & 10'h300});
    getRes(v);
    chk(32'(v), 32'h3FF);
    wr(ACS_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    $display("t_lock done");
  endtask : t_lock

  task automatic t_free();
    logic [31:0] r;
    logic [9:0] v;
    slow <= 1'b1;
    wr(ACS_MASK_OFS, 32'h0);
    wr(ACS_CHAN_OFS, 32'h1);
    wr(ACS_CTRL_OFS, 32'h17);
    while (convBusy !== 1'b1)
      @(posedge clk_sys);
    wr(ACS_CHAN_OFS, 32'h5);
    chk(32'(anaChannel), 32'h1);
    waitBit(ACS_STAT_OFS, 0, 1'b1);
    wr(ACS_STAT_OFS, 32'h1);
    chk(32'(irq), 32'h0);
    rd(ACS_CTRL_OFS, r);
    chk(32'(r[1]), 32'h1);
    chk(32'(anaChannel), 32'h5);
    wr(ACS_CHAN_OFS, 32'h2);
    chk(32'(anaChannel), 32'h5);
    waitBit(ACS_STAT_OFS, 0, 1'b1);
    getRes(v);
    chk(32'(v), 32'(lvl(5)));
    wr(ACS_CTRL_OFS, 32'h0);
    $display("t_free done");
  endtask : t_free

  initial
  begin
    slow = 1'b0;
    for (int i = 0; i < 8; i++)
      vin[i*10 +: 10] = lvl(i);
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_chans();
    t_psc();
    t_lock();
    t_free();
    print_verdict();
  end
endmodule : acs_conv_seq_tb_top
`default_nettype wire
